// File: core/csdg_pkg.sv
// Shared constants, field layouts and types of the clock select, divide and gate block.
`default_nettype none

package csdg_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [31:0] CSDG_ADDR_BUS_DIV   = 32'h0500_0000;
    localparam logic [31:0] CSDG_ADDR_TRIM      = 32'h0500_0002;
    localparam logic [31:0] CSDG_ADDR_GATES     = 32'h0500_0004;
    localparam logic [31:0] CSDG_ADDR_RADIO     = 32'h0500_0008;
    localparam logic [31:0] CSDG_ADDR_SRC_CTRL  = 32'h0500_000a;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CSDG_HDIV_LSB       = 0;    // Bus and CPU divider, two bits.
    localparam int CSDG_PDIV_LSB       = 4;    // Peripheral bus divider, two bits.
    localparam int CSDG_TRIM_LSB       = 0;    // Fine trim, eight bits.
    localparam int CSDG_QUAD_BIT       = 11;
    localparam int CSDG_SPI_BIT        = 10;
    localparam int CSDG_UART1_BIT      = 7;
    localparam int CSDG_UART2_BIT      = 6;
    localparam int CSDG_TWI_BIT        = 5;
    localparam int CSDG_WKUP_BIT       = 4;
    localparam int CSDG_TMR_BIT        = 3;
    localparam int CSDG_T0_DIV_LSB     = 0;    // Two bits.
    localparam int CSDG_RADIO_EN_BIT   = 7;
    localparam int CSDG_RADIO_RST_BIT  = 6;
    localparam int CSDG_RADIO_DIV_LSB  = 4;    // Two bits.
    localparam int CSDG_RFCU_BIT       = 3;
    localparam int CSDG_ON_XTAL_BIT    = 7;
    localparam int CSDG_ON_RC_BIT      = 6;
    localparam int CSDG_ON_LP_BIT      = 5;
    localparam int CSDG_LP_SEL_LSB     = 3;    // Two bits.
    localparam int CSDG_XOFF_BIT       = 2;
    localparam int CSDG_SYS_SEL_LSB    = 0;    // Two bits.

    // ------------------------------------------------------------------
    // Source codes and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] CSDG_SRC_XTAL    = 2'h0;
    localparam logic [1:0] CSDG_SRC_RC      = 2'h1;
    localparam logic [1:0] CSDG_SRC_LP      = 2'h2;
    localparam logic [7:0] CSDG_TRIM_RST    = 8'h80;
    localparam logic [1:0] CSDG_SYS_SEL_RST = 2'h1;
    localparam logic       CSDG_QUAD_RST    = 1'b1;
    localparam logic       CSDG_SLEEP_RST   = 1'b1;

    typedef enum logic [1:0] {CSDG_SW_IDLE, CSDG_SW_DRAIN, CSDG_SW_ACQUIRE} csdg_sw_state_t;

    // Register port request.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        logic [15:0] wdata;
    } csdg_bus_req_t;

    // Peripheral clock gate levels.
    typedef struct packed {
        logic quad;
        logic spi;
        logic uart1;
        logic uart2;
        logic twi;
        logic wkup;
        logic timers;
    } csdg_gates_t;

    // Whole state of the block.
    typedef struct packed {
        logic [4:0]     s1;
        logic [4:0]     s2;
        logic [4:0]     s3;
        logic [1:0]     hdiv;
        logic [1:0]     pdiv;
        logic [7:0]     trim;
        csdg_gates_t    gates;
        logic [1:0]     t0_div;
        logic           radio_en;
        logic           radio_rst;
        logic [1:0]     radio_div;
        logic           rfcu;
        logic [1:0]     lp_sel;
        logic           xoff;
        logic [1:0]     sys_sel;
        logic [1:0]     active;
        logic [1:0]     target;
        csdg_sw_state_t sw;
        logic [2:0]     hcnt;
        logic [2:0]     pcnt;
        logic [2:0]     tcnt;
        logic [2:0]     rcnt;
        logic           hclk_en;
        logic           pclk_en;
        logic           tmr_tick;
        logic           radio_tick;
        logic [15:0]    rdata;
    } csdg_state_t;

    localparam csdg_state_t CSDG_STATE_RST = '{
        trim:      CSDG_TRIM_RST,
        gates:     '{quad: CSDG_QUAD_RST, default: 1'b0},
        radio_rst: CSDG_SLEEP_RST,
        sys_sel:   CSDG_SYS_SEL_RST,
        active:    CSDG_SRC_RC,
        target:    CSDG_SRC_RC,
        sw:        CSDG_SW_IDLE,
        default:   '0
    };

endpackage : csdg_pkg

`default_nettype wire

// File: core/csdg_core.sv
// Clock source selection, bus and peripheral clock dividers and clock gates with register port.
//
// What this block does
// - Bus and CPU clock divided by 1/2/4/8.
// - Peripheral bus clock cascades from bus clock divider.
// - Eight-bit crystal fine trim, resets to 0x80.
// - Quadrature decoder clock gate, on after reset.
// - Wakeup capture timer clock gate, off after reset.
// - One gate for both general timers.
// - Timer zero clock divided by 1/2/4/8.
// - Radio core clocks only while enable bit set.
// - Radio sleep timer held in reset, resets set.
// - Radio core clock divided by 1/2/4/8.
// - RF control unit clock gate, off after reset.
// - Flag shows fast crystal drives system clock.
// - Flag shows fast RC drives system clock.
// - Flag shows low-power clock drives system clock.
// - Low-power clock source select, four choices.
// - Crystal-off bit stops crystal and keeps it off.
// - System clock source select, resets to fast RC.
//
// Design decision made here: the strobed register port.
`default_nettype none

module csdg_core (
    input  wire logic                   clk_sys_i,
    input  wire logic                   arst_n_i,
    input  wire csdg_pkg::csdg_bus_req_t bus_i,
    output logic [15:0]                 rdata_o,
    input  wire logic                   xtal_tick_i,
    input  wire logic                   rc_tick_i,
    input  wire logic                   lp_tick_i,
    input  wire logic                   xtal_settled_i,
    input  wire logic                   xtal_trim_done_i,
    output logic                        hclk_en_o,
    output logic                        pclk_en_o,
    output logic                        timer_zero_tick_o,
    output logic                        radio_core_tick_o,
    output csdg_pkg::csdg_gates_t       gates_o,
    output logic                        rf_control_unit_clock_gate_o,
    output logic                        radio_sleep_timer_reset_o,
    output logic [7:0]                  fast_crystal_fine_trim_o,
    output logic                        fast_crystal_enable_o,
    output logic [1:0]                  low_power_clock_source_select_o
);
    import csdg_pkg::*;

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------

    // Terminal count for a divide-by-1/2/4/8 code.
    function automatic logic [2:0] div_mask(input logic [1:0] code);
        case (code)
            2'h0:    return 3'h0;
            2'h1:    return 3'h1;
            2'h2:    return 3'h3;
            default: return 3'h7;
        endcase
    endfunction

    // One step of a tick divider: returns the divided tick above the new count.
    function automatic logic [3:0] div_step(input logic in_tick, input logic [2:0] cnt, input logic [1:0] code);
        if (!in_tick) begin
            return {1'b0, cnt};
        end
        if (cnt >= div_mask(code)) begin
            return {1'b1, 3'h0};
        end
        return {1'b0, 3'(cnt + 3'h1)};
    endfunction

    // Selection code to source; both upper codes mean the low-power clock.
    function automatic logic [1:0] src_of(input logic [1:0] sel);
        case (sel)
            2'h0:    return CSDG_SRC_XTAL;
            2'h1:    return CSDG_SRC_RC;
            default: return CSDG_SRC_LP;
        endcase
    endfunction

    // Tick of a given source out of the synchronised edge vector.
    function automatic logic tick_of(input logic [2:0] edges, input logic [1:0] src);
        case (src)
            CSDG_SRC_XTAL: return edges[0];
            CSDG_SRC_RC:   return edges[1];
            default:       return edges[2];
        endcase
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    csdg_state_t q;
    csdg_state_t n;

    // All next-state logic. Oscillator ticks arrive from foreign clocks, so they
    // pass two flops before the third stage and the edge detector read them.
    always_comb begin
        logic [2:0] edges;
        logic       src_tick;
        logic [1:0] want;
        edges    = 3'h0;
        src_tick = 1'b0;
        want     = 2'h0;
        n        = q;

        n.s1  = {xtal_trim_done_i, xtal_settled_i, lp_tick_i, rc_tick_i, xtal_tick_i};
        n.s2  = q.s1;
        n.s3  = q.s2;
        edges = q.s2[2:0] & ~q.s3[2:0];

        // Source switch. The old source delivers one last tick, then nothing
        // passes until the new source shows a rising edge, so no runt pulse
        // reaches the dividers. A source that never ticks stalls the switch.
        want = src_of(q.sys_sel);
        case (q.sw)
            CSDG_SW_IDLE: begin
                src_tick = tick_of(edges, q.active);
                if (want != q.active) begin
                    n.sw     = CSDG_SW_DRAIN;
                    n.target = want;
                end
            end
            CSDG_SW_DRAIN: begin
                if (tick_of(edges, q.active)) begin
                    src_tick = 1'b1;
                    n.sw     = CSDG_SW_ACQUIRE;
                end
            end
            CSDG_SW_ACQUIRE: begin
                if (tick_of(edges, q.target)) begin
                    n.active = q.target;
                    n.sw     = CSDG_SW_IDLE;
                end
            end
            default: begin
                n.sw = CSDG_SW_IDLE;
            end
        endcase

        // Divider chain; the peripheral bus divider counts bus clock ticks.
        {n.hclk_en, n.hcnt}       = div_step(src_tick, q.hcnt, q.hdiv);
        {n.pclk_en, n.pcnt}       = div_step(n.hclk_en, q.pcnt, q.pdiv);
        {n.tmr_tick, n.tcnt}      = div_step(src_tick & q.gates.timers, q.tcnt, q.t0_div);
        {n.radio_tick, n.rcnt}    = div_step(src_tick & q.radio_en, q.rcnt, q.radio_div);

        // Register writes. Read-only flag bits ignore written data.
        if (bus_i.wr) begin
            case (bus_i.addr)
                CSDG_ADDR_BUS_DIV: begin
                    n.hdiv = bus_i.wdata[CSDG_HDIV_LSB +: 2];
                    n.pdiv = bus_i.wdata[CSDG_PDIV_LSB +: 2];
                end
                CSDG_ADDR_TRIM: begin
                    n.trim = bus_i.wdata[CSDG_TRIM_LSB +: 8];
                end
                CSDG_ADDR_GATES: begin
                    n.gates.quad   = bus_i.wdata[CSDG_QUAD_BIT];
                    n.gates.spi    = bus_i.wdata[CSDG_SPI_BIT];
                    n.gates.uart1  = bus_i.wdata[CSDG_UART1_BIT];
                    n.gates.uart2  = bus_i.wdata[CSDG_UART2_BIT];
                    n.gates.twi    = bus_i.wdata[CSDG_TWI_BIT];
                    n.gates.wkup   = bus_i.wdata[CSDG_WKUP_BIT];
                    n.gates.timers = bus_i.wdata[CSDG_TMR_BIT];
                    n.t0_div       = bus_i.wdata[CSDG_T0_DIV_LSB +: 2];
                end
                CSDG_ADDR_RADIO: begin
                    n.radio_en  = bus_i.wdata[CSDG_RADIO_EN_BIT];
                    n.radio_rst = bus_i.wdata[CSDG_RADIO_RST_BIT];
                    n.radio_div = bus_i.wdata[CSDG_RADIO_DIV_LSB +: 2];
                    n.rfcu      = bus_i.wdata[CSDG_RFCU_BIT];
                end
                CSDG_ADDR_SRC_CTRL: begin
                    n.lp_sel  = bus_i.wdata[CSDG_LP_SEL_LSB +: 2];
                    n.xoff    = bus_i.wdata[CSDG_XOFF_BIT];
                    n.sys_sel = bus_i.wdata[CSDG_SYS_SEL_LSB +: 2];
                end
                default: begin
                end
            endcase
        end

        // Read data stand for exactly one cycle; unmapped addresses read zero.
        n.rdata = 16'h0000;
        if (bus_i.rd) begin
            case (bus_i.addr)
                CSDG_ADDR_BUS_DIV: begin
                    n.rdata[CSDG_HDIV_LSB +: 2] = q.hdiv;
                    n.rdata[CSDG_PDIV_LSB +: 2] = q.pdiv;
                end
                CSDG_ADDR_TRIM: begin
                    n.rdata[CSDG_TRIM_LSB +: 8] = q.trim;
                end
                CSDG_ADDR_GATES: begin
                    n.rdata[CSDG_QUAD_BIT]         = q.gates.quad;
                    n.rdata[CSDG_SPI_BIT]          = q.gates.spi;
                    n.rdata[CSDG_UART1_BIT]        = q.gates.uart1;
                    n.rdata[CSDG_UART2_BIT]        = q.gates.uart2;
                    n.rdata[CSDG_TWI_BIT]          = q.gates.twi;
                    n.rdata[CSDG_WKUP_BIT]         = q.gates.wkup;
                    n.rdata[CSDG_TMR_BIT]          = q.gates.timers;
                    n.rdata[CSDG_T0_DIV_LSB +: 2]  = q.t0_div;
                end
                CSDG_ADDR_RADIO: begin
                    n.rdata[CSDG_RADIO_EN_BIT]        = q.radio_en;
                    n.rdata[CSDG_RADIO_RST_BIT]       = q.radio_rst;
                    n.rdata[CSDG_RADIO_DIV_LSB +: 2]  = q.radio_div;
                    n.rdata[CSDG_RFCU_BIT]            = q.rfcu;
                end
                CSDG_ADDR_SRC_CTRL: begin
                    n.rdata[CSDG_ON_XTAL_BIT]       = (q.active == CSDG_SRC_XTAL);
                    n.rdata[CSDG_ON_RC_BIT]         = (q.active == CSDG_SRC_RC);
                    n.rdata[CSDG_ON_LP_BIT]         = (q.active == CSDG_SRC_LP);
                    n.rdata[CSDG_LP_SEL_LSB +: 2]   = q.lp_sel;
                    n.rdata[CSDG_XOFF_BIT]          = q.xoff;
                    n.rdata[CSDG_SYS_SEL_LSB +: 2]  = q.sys_sel;
                end
                default: begin
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= CSDG_STATE_RST;
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign rdata_o                         = q.rdata;
    assign hclk_en_o                       = q.hclk_en;
    assign pclk_en_o                       = q.pclk_en;
    assign timer_zero_tick_o               = q.tmr_tick;
    assign radio_core_tick_o               = q.radio_tick;
    assign gates_o                         = q.gates;
    assign rf_control_unit_clock_gate_o    = q.rfcu;
    assign radio_sleep_timer_reset_o       = q.radio_rst;
    assign fast_crystal_fine_trim_o        = q.trim;
    // The crystal stays off while the bit is set, across any sleep in between.
    assign fast_crystal_enable_o           = ~q.xoff;
    assign low_power_clock_source_select_o = q.lp_sel;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence wr_s(logic [31:0] a);
        bus_i.wr && bus_i.addr == a;
    endsequence

    sequence rd_ctrl_s;
        bus_i.rd && !bus_i.wr && bus_i.addr == CSDG_ADDR_SRC_CTRL;
    endsequence

    // A bus clock tick ends a full count of the programmed ratio and restarts the count. A code
    // lowered mid-count leaves the count above the new mask, so the compare is not an equality.
    hclk_ratio_a: assert property (hclk_en_o |-> q.hcnt == 3'h0 && $past(q.hcnt) >= div_mask($past(q.hdiv)))
        else $error("bus clock tick at wrong count");

    // The peripheral bus tick only ever rides on a bus clock tick.
    pclk_cascade_a: assert property (pclk_en_o |-> hclk_en_o)
        else $error("peripheral tick without bus tick");

    trim_write_a: assert property (wr_s(CSDG_ADDR_TRIM) |=> fast_crystal_fine_trim_o == $past(bus_i.wdata[7:0]))
        else $error("trim write not taken");

    quad_gate_a: assert property (wr_s(CSDG_ADDR_GATES) |=> gates_o.quad == $past(bus_i.wdata[CSDG_QUAD_BIT]))
        else $error("quadrature gate write not taken");

    spi_gate_a: assert property (wr_s(CSDG_ADDR_GATES) |=> gates_o.spi == $past(bus_i.wdata[CSDG_SPI_BIT])
        && gates_o.twi == $past(bus_i.wdata[CSDG_TWI_BIT]) && gates_o.wkup == $past(bus_i.wdata[CSDG_WKUP_BIT]))
        else $error("peripheral gate write not taken");

    // Timer zero ticks only while the shared timer gate is open.
    timer_gate_a: assert property (timer_zero_tick_o |-> $past(gates_o.timers) && q.tcnt == 3'h0
        && $past(q.tcnt) >= div_mask($past(q.t0_div)))
        else $error("timer tick while gated or miscounted");

    radio_gate_a: assert property (radio_core_tick_o |-> $past(q.radio_en) && q.rcnt == 3'h0
        && $past(q.rcnt) >= div_mask($past(q.radio_div)))
        else $error("radio tick while gated or miscounted");

    sleep_rst_a: assert property (wr_s(CSDG_ADDR_RADIO) |=> radio_sleep_timer_reset_o == $past(bus_i.wdata[6]))
        else $error("sleep timer reset write not taken");

    xoff_write_a: assert property (wr_s(CSDG_ADDR_SRC_CTRL) |=> fast_crystal_enable_o == !$past(bus_i.wdata[2]))
        else $error("crystal off write not taken");

    // Exactly one running flag, and the RC flag is set exactly when the fast RC is the active source.
    run_flags_a: assert property (rd_ctrl_s |=> $onehot(rdata_o[7:5]) &&
        rdata_o[CSDG_ON_RC_BIT] == ($past(q.active) == CSDG_SRC_RC))
        else $error("running flags wrong");

    // The active source changes only after the new source has ticked.
    switch_clean_a: assert property ($changed(q.active) |-> $past(q.sw) == CSDG_SW_ACQUIRE && !hclk_en_o)
        else $error("source switched outside acquire");

    // No bus clock tick can come out in the cycle after one in which a switch is acquiring the new source.
    acquire_quiet_a: assert property (q.sw == CSDG_SW_ACQUIRE |=> !hclk_en_o)
        else $error("tick during source acquire");

endmodule // csdg_core

`default_nettype wire

// File: verif/tb_clock_select_divide_gate.sv
// Self-checking testbench of the clock select, divide and gate block.
`default_nettype none

module tb_clock_select_divide_gate;
    timeunit 1ns;
    timeprecision 100ps;
    import csdg_pkg::*;

    logic          clk_sys_i = 1'b0;
    logic          arst_n_i  = 1'b0;
    csdg_bus_req_t bus_i     = '0;
    logic          xtal_t = 1'b0, rc_t = 1'b0, lp_t = 1'b0, settled = 1'b0, trim_ok = 1'b0;
    logic [15:0]   rdata;
    logic          hclk, pclk, tmr, rad, rfcu, slp, xen;
    csdg_gates_t   gates;
    logic [7:0]    trim;
    logic [1:0]    lps;
    logic [7:0]    src_cnt = '0;
    int            miscompares = 0, checked = 0, seed = 31, cycles = 0;
    int            gbit [7] = '{11, 10, 7, 6, 5, 4, 3};

    csdg_core u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .bus_i(bus_i), .rdata_o(rdata),
        .xtal_tick_i(xtal_t), .rc_tick_i(rc_t), .lp_tick_i(lp_t), .xtal_settled_i(settled),
        .xtal_trim_done_i(trim_ok), .hclk_en_o(hclk), .pclk_en_o(pclk), .timer_zero_tick_o(tmr),
        .radio_core_tick_o(rad), .gates_o(gates), .rf_control_unit_clock_gate_o(rfcu),
        .radio_sleep_timer_reset_o(slp), .fast_crystal_fine_trim_o(trim),
        .fast_crystal_enable_o(xen), .low_power_clock_source_select_o(lps));

    // Clock; the sources run free with periods of 8 (crystal), 4 (RC) and 16 (low power) cycles.
    always #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        src_cnt <= src_cnt + 8'h01;
        xtal_t  <= src_cnt[2];
        rc_t    <= src_cnt[1];
        lp_t    <= src_cnt[3];
        cycles  <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // Bus and comparison helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus_wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        bus_i.wr    <= 1'b1;
        bus_i.addr  <= a;
        bus_i.wdata <= d;
        @(posedge clk_sys_i);
        bus_i.wr    <= 1'b0;
        // Step off the edge so a caller sees the written state settled.
        #1;
    endtask

    // Reads, compares, then sees that the data drop back to zero one cycle on.
    task automatic rd_chk(input logic [31:0] a, input logic [15:0] exp, input string what);
        @(posedge clk_sys_i);
        bus_i.rd   <= 1'b1;
        bus_i.addr <= a;
        @(posedge clk_sys_i);
        bus_i.rd   <= 1'b0;
        #1 check(what, rdata, exp);
        @(posedge clk_sys_i);
        #1 check("rdata idle", rdata, 16'h0000);
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return hclk;
            1: return pclk;
            2: return tmr;
            default: return rad;
        endcase
    endfunction

    // Gap between the second and third pulse, so a code change mid-count cannot skew it; 0 if none.
    task automatic interval(input int s, output int gap);
        int k, last, hits;
        hits = 0;
        last = 0;
        gap  = 0;
        for (k = 0; k < 1000 && hits < 3; k++) begin
            @(posedge clk_sys_i);
            #1;
            if (pick(s) === 1'b1) begin
                gap  = (hits == 0) ? 0 : k - last;
                last = k;
                hits++;
            end
        end
    endtask

    function automatic logic [15:0] gap_of(input int period, input int code);
        return 16'(period << code);
    endfunction

    task automatic tally_and_finish();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [15:0] d;
        int i, g, h, p, t, r;
        repeat (6) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        rd_chk(CSDG_ADDR_SRC_CTRL, 16'h0041, "src_ctrl");
        rd_chk(CSDG_ADDR_TRIM, 16'h0080, "trim");
        rd_chk(CSDG_ADDR_GATES, 16'h0800, "gates");
        rd_chk(CSDG_ADDR_RADIO, 16'h0040, "radio");
        rd_chk(CSDG_ADDR_BUS_DIV, 16'h0000, "bus_div");
        check("gates_o", 16'(gates), 16'h0040);
        check("outs", {3'h0, rfcu, slp, xen, lps, trim}, 16'h0c80);
        // Trim corners first, then random values.
        for (i = 0; i < 6; i++) begin
            d = (i == 0) ? 16'h0000 : (i == 1) ? 16'h00ff : 16'($random(seed));
            bus_wr(CSDG_ADDR_TRIM, d);
            rd_chk(CSDG_ADDR_TRIM, d & 16'h00ff, "trim");
            check("trim_o", {8'h00, trim}, d & 16'h00ff);
        end
        // Divide codes; radio kept between the CPU rate and a quarter of the source.
        for (i = 0; i < 8; i++) begin
            h = (i < 2) ? 2 * i : {$random(seed)} % 3;
            r = (i < 2) ? h : h + {$random(seed)} % (3 - h);
            p = (i < 2) ? 3 * i : {$random(seed)} % 4;
            t = (i < 2) ? 3 * i : {$random(seed)} % 4;
            bus_wr(CSDG_ADDR_BUS_DIV, 16'((p << 4) | h));
            bus_wr(CSDG_ADDR_GATES, 16'(8 | t));
            bus_wr(CSDG_ADDR_RADIO, 16'(8'h80 | (r << 4)));
            rd_chk(CSDG_ADDR_RADIO, 16'(8'h80 | (r << 4)), "radio");
            interval(0, g);
            check("hclk gap", 16'(g), gap_of(4, h));
            interval(1, g);
            check("pclk gap", 16'(g), gap_of(4, h + p));
            interval(2, g);
            check("timer gap", 16'(g), gap_of(4, t));
            interval(3, g);
            check("radio gap", 16'(g), gap_of(4, r));
            check("sleep_rst", {15'h0, slp}, 16'h0000);
        end
        bus_wr(CSDG_ADDR_GATES, 16'h0000);
        bus_wr(CSDG_ADDR_RADIO, 16'h0048);
        check("rfcu", {14'h0, rfcu, slp}, 16'h0003);
        interval(2, g);
        check("timer gated", 16'(g), 16'h0000);
        interval(3, g);
        check("radio gated", 16'(g), 16'h0000);
        // Divide by eight only with the radio stopped, as its clock would fall below the floor.
        bus_wr(CSDG_ADDR_BUS_DIV, 16'h0003);
        interval(0, g);
        check("hclk gap", 16'(g), gap_of(4, 3));
        for (i = 0; i < 7; i++) begin
            bus_wr(CSDG_ADDR_GATES, 16'h0001 << gbit[i]);
            check("gate bit", 16'(gates), 16'h0040 >> i);
        end
        bus_wr(32'h0500_0006, 16'hffff);
        rd_chk(32'h0500_0006, 16'h0000, "unmapped");
        rd_chk(CSDG_ADDR_GATES, 16'h0008, "gates kept");
        bus_wr(CSDG_ADDR_SRC_CTRL, 16'h00e1);
        rd_chk(CSDG_ADDR_SRC_CTRL, 16'h0041, "flags ro");
        // Low-power source changed only while that clock is unused.
        for (i = 0; i < 4; i++) begin
            bus_wr(CSDG_ADDR_SRC_CTRL, 16'((i << 3) | 1));
            check("lp_sel", {14'h0, lps}, 16'(i));
            rd_chk(CSDG_ADDR_SRC_CTRL, 16'(8'h41 | (i << 3)), "lp_sel rd");
        end
        bus_wr(CSDG_ADDR_SRC_CTRL, 16'h0005);
        check("xtal off", {15'h0, xen}, 16'h0000);
        rd_chk(CSDG_ADDR_SRC_CTRL, 16'h0045, "xoff rd");
        bus_wr(CSDG_ADDR_SRC_CTRL, 16'h0001);
        settled <= 1'b1;
        trim_ok <= 1'b1;
        // Crystal off stays clear while running on the crystal.
        bus_wr(CSDG_ADDR_BUS_DIV, 16'h0000);
        bus_wr(CSDG_ADDR_SRC_CTRL, 16'h0000);
        repeat (60) @(posedge clk_sys_i);
        rd_chk(CSDG_ADDR_SRC_CTRL, 16'h0080, "on xtal");
        interval(0, g);
        check("xtal gap", 16'(g), gap_of(8, 0));
        for (i = 2; i < 4; i++) begin
            bus_wr(CSDG_ADDR_SRC_CTRL, 16'(i));
            repeat (100) @(posedge clk_sys_i);
            rd_chk(CSDG_ADDR_SRC_CTRL, 16'(8'h20 | i), "on lp");
        end
        interval(0, g);
        check("lp gap", 16'(g), gap_of(16, 0));
        bus_wr(CSDG_ADDR_SRC_CTRL, 16'h0001);
        repeat (100) @(posedge clk_sys_i);
        rd_chk(CSDG_ADDR_SRC_CTRL, 16'h0041, "on rc");
        tally_and_finish();
    end

endmodule // tb_clock_select_divide_gate

`default_nettype wire
